// *** bench/bss_strap_model.sv ***
// Board strap resistor model that sets the strap pin levels
`timescale 1ns/10ps
`include "bss_defines.svh"

module bss_strap_model (
	input wire logic [`BSS_NSTRAP-1:0] strap_code, // Resistor pattern
	output logic [`BSS_NSTRAP-1:0] strap_pins // Levels at the pins
);
	// Each pin sits on a pull resistor, so it never floats
	assign strap_pins = strap_code;
endmodule : bss_strap_model

// *** bench/tb.sv ***
// Testbench for the strap sampler: decode, hold, registers, reset
`timescale 1ns/10ps
`include "bss_defines.svh"

module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [`BSS_NSTRAP-1:0] code = 5'h00;
	logic [`BSS_NSTRAP-1:0] pins;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd, e;
	logic strap_done, flash_1v8, boot_download, boot_normal;
	logic boot_reserved, dbg_print_en, sdio_in_rise, sdio_out_rise;
	logic [7:0] outs;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;

	assign outs = {dbg_print_en, sdio_out_rise, sdio_in_rise,
		boot_reserved, boot_normal, boot_download, flash_1v8, strap_done};

	always #12.5 aclk = ~aclk;

	bss_strap_model bss_strap_model_inst (.strap_code(code),
		.strap_pins(pins));

	bss_top bss_top_inst (.aclk(aclk), .aresetn(aresetn),
		.strap_pins(pins), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.strap_done(strap_done), .flash_1v8(flash_1v8),
		.boot_download(boot_download), .boot_normal(boot_normal),
		.boot_reserved(boot_reserved), .dbg_print_en(dbg_print_en),
		.sdio_in_rise(sdio_in_rise), .sdio_out_rise(sdio_out_rise));

	// =====================================================
	// Checking and closing
	task end_of_test;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	task chk(input logic [33:0] seen, input logic [33:0] exp,
		input string msg);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, msg,
				seen, exp);
		end
	endtask : chk

	// Catches a hung handshake; the whole run needs about 500 cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_of_test;
		end
	end

	// Expected STATUS word for a strap pattern and mute bit
	function automatic logic [31:0] exp_st(input logic [4:0] c,
		input logic m);
		exp_st = {23'h0, c[4] & ~m, c[3], c[4], c[4], c[2:1] == 2'b01,
			c[2], c[2:1] == 2'b00, c[0], 1'b1};
	endfunction : exp_st

	function automatic logic [7:0] exp_out(input logic [31:0] s);
		exp_out = {s[8:6], s[4:0]};
	endfunction : exp_out

	// =====================================================
	// AXI4-Lite master
	task wr_reg(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (pa && awready === 1'b1) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready === 1'b1) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end while (pa || pw);
		while (bvalid !== 1'b1) @(posedge aclk);
		r = bresp;
		bready <= 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd_reg

	// Reset with a new resistor pattern, then wait for capture
	task boot(input logic [4:0] c);
		@(posedge aclk);
		aresetn <= 1'b0;
		code <= c;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		#1;
		chk(outs, 34'h0, "outputs before capture");
		while (strap_done !== 1'b1) @(posedge aclk);
		// Debug enable lags the capture by one cycle
		@(posedge aclk);
		#1;
		e = exp_st(c, 1'b0);
		chk(outs[4:0], e[4:0], "boot decode");
		chk(outs[7:5], e[8:6], "edge decode");
	endtask : boot

	// =====================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			boot(i[4:0]);
			rd_reg(`BSS_OFS_STATUS, rd, rsp);
			chk({rsp, rd}, {`BSS_RESP_OKAY, e}, "status");
		end
		e = exp_st(5'h1F, 1'b0);
		// Pins reused as ordinary I/O after capture
		code <= 5'h00;
		repeat (10) @(posedge aclk);
		chk(outs, exp_out(e), "held after pin change");
		rd_reg(`BSS_OFS_RAW, rd, rsp);
		chk({rsp, rd}, {`BSS_RESP_OKAY, 32'h0000_1F00}, "raw");
		// Mute bit lane disabled: write must leave the bit alone
		wstrb <= 4'hE;
		wr_reg(`BSS_OFS_CTRL, 32'h1, rsp);
		wstrb <= 4'hF;
		chk(rsp, `BSS_RESP_OKAY, "masked ctrl write");
		rd_reg(`BSS_OFS_CTRL, rd, rsp);
		chk({rsp, rd}, {`BSS_RESP_OKAY, 32'h0}, "ctrl strobe off");
		wr_reg(`BSS_OFS_CTRL, 32'h1, rsp);
		chk(rsp, `BSS_RESP_OKAY, "ctrl write");
		rd_reg(`BSS_OFS_CTRL, rd, rsp);
		chk({rsp, rd}, {`BSS_RESP_OKAY, 32'h1}, "ctrl read");
		wr_reg(`BSS_OFS_STATUS, 32'h0, rsp);
		chk(rsp, `BSS_RESP_OKAY, "status write ignored");
		rd_reg(`BSS_OFS_STATUS, rd, rsp);
		chk({rsp, rd}, {`BSS_RESP_OKAY, exp_st(5'h1F, 1'b1)}, "muted");
		chk(dbg_print_en, 1'b0, "mute pin");
		rd_reg(8'h0C, rd, rsp);
		chk({rsp, rd}, {`BSS_RESP_SLVERR, 32'h0}, "unmapped read");
		wr_reg(8'h0C, 32'h1, rsp);
		chk(rsp, `BSS_RESP_SLVERR, "unmapped write");
		// A second reset must also clear the mute bit
		boot(5'h1F);
		rd_reg(`BSS_OFS_CTRL, rd, rsp);
		chk({rsp, rd}, {`BSS_RESP_OKAY, `BSS_CTRL_RST}, "ctrl reset");
		end_of_test;
	end
endmodule : tb

// *** src/bss_defines.svh ***
// Strap sampler constants: pin indices, register map, fields, timing
`ifndef BSS_DEFINES_SVH
`define BSS_DEFINES_SVH

// =====================================================
// Strap vector bit positions
`define BSS_NSTRAP 5
`define BSS_PIN_FLASH 0
`define BSS_PIN_BOOT_LO 1
`define BSS_PIN_BOOT_HI 2
`define BSS_PIN_SDIO_LO 3
`define BSS_PIN_DBG 4

// =====================================================
// Register byte offsets
`define BSS_OFS_STATUS 8'h00
`define BSS_OFS_CTRL 8'h04
`define BSS_OFS_RAW 8'h08

// =====================================================
// Status fields
`define BSS_ST_DONE 0
`define BSS_ST_FLASH_1V8 1
`define BSS_ST_DOWNLOAD 2
`define BSS_ST_NORMAL 3
`define BSS_ST_RESERVED 4
`define BSS_ST_DBG_STRAP 5
`define BSS_ST_SDIO_IN_RISE 6
`define BSS_ST_SDIO_OUT_RISE 7
`define BSS_ST_DBG_PRINT 8

// =====================================================
// Control fields, raw layout, reset values
`define BSS_CTRL_MUTE 0
`define BSS_CTRL_RST 32'h0000_0000
`define BSS_RAW_AGREE_LSB 8

// =====================================================
// Response codes and timing
`define BSS_RESP_OKAY 2'h0
`define BSS_RESP_SLVERR 2'h2
`define BSS_SETTLE_CYC 3'h4

`endif

// *** src/bss_pkg.sv ***
// Types shared by the strap sampler modules
package bss_pkg;

	// =====================================================
	// Sampler states
	typedef enum logic [1:0] {
		st_wait = 2'b01,
		st_hold = 2'b10
	} bss_state_t;

endpackage : bss_pkg

// *** src/bss_strap_if.sv ***
// Carrier between the strap synchroniser and the sampler core
`timescale 1ns/10ps
`include "bss_defines.svh"

interface bss_strap_if;
	logic [`BSS_NSTRAP-1:0] raw;
	logic [`BSS_NSTRAP-1:0] val;
	logic [`BSS_NSTRAP-1:0] agree;

	modport sync_side (
		input raw,
		output val,
		output agree
	);
	modport user (
		output raw,
		input val,
		input agree
	);
endinterface : bss_strap_if

// *** src/bss_sync.sv ***
// Three-stage synchroniser for the strap pins
`timescale 1ns/10ps
`include "bss_defines.svh"

module bss_sync (
	input wire logic clk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	bss_strap_if.sync_side sif // Pins in, filtered levels out
);

	// =====================================================
	// Per-pin chain
	genvar gi;
	generate
		for (gi = 0; gi < `BSS_NSTRAP; gi = gi + 1) begin : g_pin
			logic s1_r;
			logic s2_r;
			logic s3_r;
			always_ff @(posedge clk) begin
				if (!aresetn) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
				end else begin
					s1_r <= sif.raw[gi];
					s2_r <= s1_r;
					s3_r <= s2_r;
				end
			end
			// First stage is read only by the second
			assign sif.val[gi] = s3_r;
			assign sif.agree[gi] = (s2_r == s3_r);
		end
	endgenerate

endmodule : bss_sync

// *** src/bss_top.sv ***
// Boot strap sampler core with AXI4-Lite register access
`timescale 1ns/10ps
`include "bss_defines.svh"

// Summary of operation
// RULE_01: Board holds each strap pin at a defined level via resistors.
// RULE_02: Flash supply strap 0 selects 3.3V, 1 selects 1.8V.
// RULE_03: Boot mode 00 download, 01 reserved, 10 or 11 normal flash boot.
// RULE_04: Debug strap 0 keeps boot silent, 1 enables serial boot messages.
// RULE_05: Two-bit strap selects SDIO slave input and output clock edges.
// RULE_06: Board leaves internally defaulted pins undriven and prefers other pins.
// RULE_07: Low reset reboots everything; sampling restarts on its release.
// RULE_08: Straps sampled once after reset and held until next reset.
module bss_top (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [`BSS_NSTRAP-1:0] strap_pins, // Strap pin levels
	input wire logic [7:0] awaddr, // Write address
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Write byte strobes
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [7:0] araddr, // Read address
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	output logic strap_done, // Settings captured
	output logic flash_1v8, // Flash supply 1.8V selected
	output logic boot_download, // Download boot selected
	output logic boot_normal, // Normal flash boot selected
	output logic boot_reserved, // Reserved boot code seen
	output logic dbg_print_en, // Boot messages on primary_serial_port
	output logic sdio_in_rise, // SDIO slave samples on rising edge
	output logic sdio_out_rise // SDIO slave drives on rising edge
);

	// =====================================================
	// Synchroniser
	bss_strap_if sif ();
	assign sif.raw = strap_pins;

	bss_sync u_sync (
		.clk(aclk),
		.aresetn(aresetn),
		.sif(sif)
	);

	// =====================================================
	// Sampling sequence
	bss_pkg::bss_state_t state_r;
	logic [2:0] cnt_r;
	logic go;
	logic mute_r;
	logic dbg_strap_r;

	// Wait until the chain holds real pin levels, then take one snapshot
	assign go = (state_r == bss_pkg::st_wait) &&
		(cnt_r == `BSS_SETTLE_CYC) && (&sif.agree);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= bss_pkg::st_wait; // [RULE_07]
			cnt_r <= 3'h0;
		end else begin
			unique case (state_r)
				bss_pkg::st_wait: begin
					if (cnt_r != `BSS_SETTLE_CYC) begin
						cnt_r <= cnt_r + 3'h1;
					end
					if (go) begin
						state_r <= bss_pkg::st_hold; // [RULE_08]
					end
				end
				bss_pkg::st_hold: begin
					state_r <= bss_pkg::st_hold; // [RULE_08]
				end
			endcase
		end
	end

	// Decoded settings change only on the single capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_done <= 1'b0; // [RULE_07]
			flash_1v8 <= 1'b0;
			boot_download <= 1'b0;
			boot_normal <= 1'b0;
			boot_reserved <= 1'b0;
			dbg_strap_r <= 1'b0;
			sdio_in_rise <= 1'b0;
			sdio_out_rise <= 1'b0;
		end else if (go) begin
			strap_done <= 1'b1; // [RULE_08]
			flash_1v8 <= sif.val[`BSS_PIN_FLASH]; // [RULE_02]
			boot_download <= ~sif.val[`BSS_PIN_BOOT_HI] &
				~sif.val[`BSS_PIN_BOOT_LO]; // [RULE_03]
			boot_normal <= sif.val[`BSS_PIN_BOOT_HI]; // [RULE_03]
			// Reserved code boots nothing; flagged for software
			boot_reserved <= ~sif.val[`BSS_PIN_BOOT_HI] &
				sif.val[`BSS_PIN_BOOT_LO]; // [RULE_03]
			dbg_strap_r <= sif.val[`BSS_PIN_DBG]; // [RULE_04]
			sdio_in_rise <= sif.val[`BSS_PIN_DBG]; // [RULE_05]
			sdio_out_rise <= sif.val[`BSS_PIN_SDIO_LO]; // [RULE_05]
		end
	end

	// Software may silence messages, never enable them against the strap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dbg_print_en <= 1'b0;
		end else begin
			dbg_print_en <= dbg_strap_r & ~mute_r; // [RULE_04]
		end
	end

	// =====================================================
	// Register views
	logic [31:0] status_w;
	logic [31:0] raw_w;

	always_comb begin
		status_w = 32'h0000_0000;
		status_w[`BSS_ST_DONE] = strap_done;
		status_w[`BSS_ST_FLASH_1V8] = flash_1v8;
		status_w[`BSS_ST_DOWNLOAD] = boot_download;
		status_w[`BSS_ST_NORMAL] = boot_normal;
		status_w[`BSS_ST_RESERVED] = boot_reserved;
		status_w[`BSS_ST_DBG_STRAP] = dbg_strap_r;
		status_w[`BSS_ST_SDIO_IN_RISE] = sdio_in_rise;
		status_w[`BSS_ST_SDIO_OUT_RISE] = sdio_out_rise;
		status_w[`BSS_ST_DBG_PRINT] = dbg_print_en;
		raw_w = 32'h0000_0000;
		raw_w[`BSS_NSTRAP-1:0] = sif.val;
		raw_w[`BSS_RAW_AGREE_LSB +: `BSS_NSTRAP] = sif.agree;
	end

	// =====================================================
	// AXI4-Lite write channel
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_go;

	// Address and data may arrive in either order
	assign wr_go = !awready && !wready && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `BSS_RESP_OKAY;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				unique case (aw_addr_r)
					`BSS_OFS_STATUS, `BSS_OFS_CTRL, `BSS_OFS_RAW: begin
						bresp <= `BSS_RESP_OKAY;
					end
					default: begin
						bresp <= `BSS_RESP_SLVERR;
					end
				endcase
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mute_r <= 1'(`BSS_CTRL_RST);
		end else if (wr_go && (aw_addr_r == `BSS_OFS_CTRL) && w_strb_r[0]) begin
			mute_r <= w_data_r[`BSS_CTRL_MUTE];
		end
	end

	// =====================================================
	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `BSS_RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rresp <= `BSS_RESP_OKAY;
				unique case (araddr)
					`BSS_OFS_STATUS: begin
						rdata <= status_w;
					end
					`BSS_OFS_CTRL: begin
						rdata <= {31'h0000_0000, mute_r};
					end
					`BSS_OFS_RAW: begin
						rdata <= raw_w;
					end
					default: begin
						rdata <= 32'h0000_0000;
						rresp <= `BSS_RESP_SLVERR;
					end
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// =====================================================
	// Checks
	flash_select_a: assert property ( // [RULE_02]
		@(posedge aclk) disable iff (!aresetn)
		go |=> (flash_1v8 == $past(sif.val[`BSS_PIN_FLASH])))
		else $error("flash supply select does not follow strap");

	boot_decode_a: assert property ( // [RULE_03]
		@(posedge aclk) disable iff (!aresetn)
		go |=> (boot_download ==
		($past(sif.val[`BSS_PIN_BOOT_HI:`BSS_PIN_BOOT_LO]) == 2'h0)) &&
		(boot_normal == $past(sif.val[`BSS_PIN_BOOT_HI])) &&
		(boot_reserved ==
		($past(sif.val[`BSS_PIN_BOOT_HI:`BSS_PIN_BOOT_LO]) == 2'h1)))
		else $error("boot mode decode wrong");

	boot_onehot_a: assert property ( // [RULE_03]
		@(posedge aclk) disable iff (!aresetn)
		strap_done |-> $onehot({boot_download, boot_normal, boot_reserved}))
		else $error("boot mode outputs not exclusive");

	// Cross-checked against the sdio copy of the same pin
	debug_gate_a: assert property ( // [RULE_04]
		@(posedge aclk) disable iff (!aresetn)
		strap_done ##1 strap_done |->
		(dbg_print_en == (sdio_in_rise & ~$past(mute_r))))
		else $error("debug print enable wrong");

	silent_before_a: assert property ( // [RULE_04]
		@(posedge aclk) disable iff (!aresetn)
		!strap_done |-> !dbg_print_en)
		else $error("debug print enabled before capture");

	sdio_edges_a: assert property ( // [RULE_05]
		@(posedge aclk) disable iff (!aresetn)
		go |=> (sdio_in_rise == $past(sif.val[`BSS_PIN_DBG])) &&
		(sdio_out_rise == $past(sif.val[`BSS_PIN_SDIO_LO])))
		else $error("sdio edge timing wrong");

	reset_restart_a: assert property ( // [RULE_07]
		@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> !strap_done [*4])
		else $error("settings captured too early after reset");

	settings_hold_a: assert property ( // [RULE_08]
		@(posedge aclk) disable iff (!aresetn)
		strap_done |=> strap_done && $stable(flash_1v8) &&
		$stable(boot_normal) && $stable(boot_download) &&
		$stable(boot_reserved) && $stable(sdio_in_rise) &&
		$stable(sdio_out_rise))
		else $error("captured settings changed");

	// Response is launched one edge after both halves are latched
	write_resp_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(awvalid && awready && wvalid && wready) |-> ##2 bvalid)
		else $error("write response missing");

	read_resp_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(arvalid && arready) |=> rvalid)
		else $error("read response missing");

endmodule : bss_top
